// >>> exec_subset.sv
// Notes on behaviour
// - Memory rotate right through carry, written back
// - Accumulator rotate form leaves memory unchanged
// - Subtract memory and inverted carry into accumulator
// - Borrow subtract form writes result to memory
// - Carry clear if negative, set otherwise
// - Plain subtract to accumulator or memory
// - Immediate subtract into accumulator, flags updated
// - Decrement memory, skip on zero, flags kept
// - Increment memory, skip on zero, flags kept
// - Accumulator step forms skip on zero result
// - A skip adds one dummy instruction cycle
// - Byte set writes all ones, flags kept
// - Bit set forces selected bit to one
// - Skip when selected memory bit is one
// - Skip when selected memory bit is zero
// - Skip when whole memory byte is zero
// - Copy byte to accumulator, skip if zero
// - Nibble swap to memory or accumulator only
// - Table read uses high and low pointers
// - Last page table read uses low pointer
// - Exclusive-or to accumulator or memory, zero flag
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "exec_subset_consts.svh"

module exec_subset #(
  parameter int DM_DEPTH = 256
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Register bus
  input wire exec_subset_pkg::apb_req_t i_apb,
  output exec_subset_pkg::apb_rsp_t o_apb,
  // Program memory read port, data one cycle after the address
  output logic [15:0] o_prog_addr,
  output logic o_prog_rd,
  input wire logic [15:0] i_prog_data,
  // Execution status
  output logic o_busy,
  output logic o_skip,
  output logic o_dummy_cycle
);

  exec_subset_pkg::state_t state;
  exec_subset_pkg::state_t next_state;

  logic [7:0] data_mem [DM_DEPTH];
  logic mem_we;
  logic [7:0] mem_wa;
  logic [7:0] mem_wd;

  // True when an address is word aligned and falls in the data memory window
  function automatic logic in_mem_window(input logic [11:0] a);
    logic [11:0] rel;
    rel = a - `REG_MEM_BASE;
    in_mem_window = (a >= `REG_MEM_BASE) && (32'(rel[11:2]) < DM_DEPTH) && (a[1:0] == 2'b00);
  endfunction : in_mem_window

  // Zero test shared by flags and skips
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == `BYTE_ZERO);
  endfunction : is_zero

  always_comb
  begin
    logic [7:0] m;
    logic [7:0] sb;
    logic borrow_in;
    logic [8:0] diff9;
    logic [4:0] low5;
    logic [7:0] res;
    logic [7:0] mask;
    logic [11:0] rel;
    logic first_access;
    logic complete;
    m = `BYTE_ZERO;
    sb = `BYTE_ZERO;
    borrow_in = 1'b0;
    diff9 = 9'h000;
    low5 = 5'h00;
    res = `BYTE_ZERO;
    mask = `BYTE_ZERO;
    rel = i_apb.paddr - `REG_MEM_BASE;
    first_access = i_apb.psel && i_apb.penable && !state.apb.pready;
    complete = i_apb.psel && i_apb.penable && state.apb.pready;
    next_state = state;
    next_state.prog_rd = 1'b0;
    mem_we = 1'b0;
    mem_wa = state.addr;
    mem_wd = `BYTE_ZERO;

    // Register bus: answer one cycle into the access phase
    next_state.apb.pready = first_access;
    if (first_access)
    begin
      next_state.apb.pslverr = 1'b0;
      next_state.apb.prdata = 32'h0000_0000;
      if (in_mem_window(i_apb.paddr))
      begin
        next_state.apb.prdata = {24'h00_0000, data_mem[rel[9:2]]};
        next_state.apb.pslverr = i_apb.pwrite && (state.fsm != exec_subset_pkg::ST_IDLE);
      end
      else
      begin
        case (i_apb.paddr)
          `REG_CTRL:
          begin
            next_state.apb.prdata = {state.imm, 5'h00, state.bitsel, state.addr, 2'b00, state.op};
            next_state.apb.pslverr = i_apb.pwrite && (state.fsm != exec_subset_pkg::ST_IDLE);
          end
          `REG_STATUS:
          begin
            next_state.apb.prdata[`ST_C] = state.flags.carry;
            next_state.apb.prdata[`ST_NIBBLE_BORROW] = state.flags.nibble_borrow_flag;
            next_state.apb.prdata[`ST_Z] = state.flags.zero;
            next_state.apb.prdata[`ST_SIGNED_WRAP] = state.flags.signed_wrap_flag;
            next_state.apb.prdata[`ST_BUSY] = (state.fsm != exec_subset_pkg::ST_IDLE);
            next_state.apb.prdata[`ST_SKIP] = state.skip;
            next_state.apb.prdata[`ST_BAD_OP] = state.bad_op;
            next_state.apb.pslverr = i_apb.pwrite && (state.fsm != exec_subset_pkg::ST_IDLE);
          end
          `REG_ACC:
          begin
            next_state.apb.prdata = {24'h00_0000, state.acc};
            next_state.apb.pslverr = i_apb.pwrite && (state.fsm != exec_subset_pkg::ST_IDLE);
          end
          `REG_TABLE_PTR_LOW:
          begin
            next_state.apb.prdata = {24'h00_0000, state.table_pointer_low};
          end
          `REG_TABLE_PTR_HIGH:
          begin
            next_state.apb.prdata = {24'h00_0000, state.table_pointer_high};
          end
          `REG_TABLE_HIGH_LATCH:
          begin
            next_state.apb.prdata = {24'h00_0000, state.table_high_byte_latch};
            next_state.apb.pslverr = i_apb.pwrite;
          end
          `REG_CYCLES:
          begin
            next_state.apb.prdata = {30'h0000_0000, state.cycles};
            next_state.apb.pslverr = i_apb.pwrite;
          end
          default:
          begin
            next_state.apb.pslverr = 1'b1;
          end
        endcase
      end
    end

    // Writes take effect at the completing edge only
    if (complete && i_apb.pwrite && !state.apb.pslverr)
    begin
      if (in_mem_window(i_apb.paddr))
      begin
        mem_we = 1'b1;
        mem_wa = rel[9:2];
        mem_wd = i_apb.pwdata[7:0];
      end
      else
      begin
        case (i_apb.paddr)
          `REG_CTRL:
          begin
            next_state.op = exec_subset_pkg::op_t'(i_apb.pwdata[`CTRL_OP_MSB:`CTRL_OP_LSB]);
            next_state.addr = i_apb.pwdata[`CTRL_ADDR_MSB:`CTRL_ADDR_LSB];
            next_state.bitsel = i_apb.pwdata[`CTRL_BIT_MSB:`CTRL_BIT_LSB];
            next_state.imm = i_apb.pwdata[`CTRL_IMM_MSB:`CTRL_IMM_LSB];
            next_state.fsm = exec_subset_pkg::ST_EXEC;
          end
          `REG_STATUS:
          begin
            next_state.flags.carry = i_apb.pwdata[`ST_C];
            next_state.flags.nibble_borrow_flag = i_apb.pwdata[`ST_NIBBLE_BORROW];
            next_state.flags.zero = i_apb.pwdata[`ST_Z];
            next_state.flags.signed_wrap_flag = i_apb.pwdata[`ST_SIGNED_WRAP];
          end
          `REG_ACC:
          begin
            next_state.acc = i_apb.pwdata[7:0];
          end
          `REG_TABLE_PTR_LOW:
          begin
            next_state.table_pointer_low = i_apb.pwdata[7:0];
          end
          `REG_TABLE_PTR_HIGH:
          begin
            next_state.table_pointer_high = i_apb.pwdata[7:0];
          end
          default:
          begin
          end
        endcase
      end
    end

    // Instruction sequencer
    case (state.fsm)
      exec_subset_pkg::ST_IDLE:
      begin
      end
      exec_subset_pkg::ST_EXEC:
      begin
        m = data_mem[state.addr];
        mask = 8'(`BYTE_ONE << state.bitsel);
        next_state.skip = 1'b0;
        next_state.bad_op = 1'b0;
        next_state.cycles = `ONE_CYCLE;
        next_state.fsm = exec_subset_pkg::ST_IDLE;
        // Shared subtractor; borrow-in only for the borrow forms
        sb = (state.op == exec_subset_pkg::OP_SUBTRACT_IMMEDIATE) ? state.imm : m;
        borrow_in = ((state.op == exec_subset_pkg::OP_SUBTRACT_WITH_BORROW) ||
                     (state.op == exec_subset_pkg::OP_SUBTRACT_BORROW_TO_MEMORY)) &&
                    !state.flags.carry;
        diff9 = {1'b0, state.acc} - {1'b0, sb} - {8'h00, borrow_in};
        low5 = {1'b0, state.acc[3:0]} - {1'b0, sb[3:0]} - {4'h0, borrow_in};
        case (state.op)
          exec_subset_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY:
          begin
            mem_we = 1'b1;
            mem_wd = {state.flags.carry, m[7:1]};
            next_state.flags.carry = m[0];
          end
          exec_subset_pkg::OP_ROTATE_RIGHT_CARRY_TO_ACCUMULATOR:
          begin
            next_state.acc = {state.flags.carry, m[7:1]};
            next_state.flags.carry = m[0];
          end
          exec_subset_pkg::OP_SUBTRACT_WITH_BORROW,
          exec_subset_pkg::OP_SUBTRACT_BORROW_TO_MEMORY,
          exec_subset_pkg::OP_SUBTRACT,
          exec_subset_pkg::OP_SUBTRACT_TO_MEMORY,
          exec_subset_pkg::OP_SUBTRACT_IMMEDIATE:
          begin
            res = diff9[7:0];
            if ((state.op == exec_subset_pkg::OP_SUBTRACT_BORROW_TO_MEMORY) ||
                (state.op == exec_subset_pkg::OP_SUBTRACT_TO_MEMORY))
            begin
              mem_we = 1'b1;
              mem_wd = res;
            end
            else
            begin
              next_state.acc = res;
            end
            next_state.flags.carry = !diff9[8];
            next_state.flags.nibble_borrow_flag = low5[4];
            next_state.flags.zero = is_zero(res);
            next_state.flags.signed_wrap_flag = (state.acc[7] ^ sb[7]) &
                                                (state.acc[7] ^ res[7]);
          end
          exec_subset_pkg::OP_DECREMENT_SKIP_IF_ZERO,
          exec_subset_pkg::OP_INCREMENT_SKIP_IF_ZERO:
          begin
            res = (state.op == exec_subset_pkg::OP_DECREMENT_SKIP_IF_ZERO) ?
                  8'(m - `BYTE_ONE) : 8'(m + `BYTE_ONE);
            mem_we = 1'b1;
            mem_wd = res;
            next_state.skip = is_zero(res);
          end
          exec_subset_pkg::OP_DECREMENT_SKIP_TO_ACCUMULATOR,
          exec_subset_pkg::OP_INCREMENT_SKIP_TO_ACCUMULATOR:
          begin
            res = (state.op == exec_subset_pkg::OP_DECREMENT_SKIP_TO_ACCUMULATOR) ?
                  8'(m - `BYTE_ONE) : 8'(m + `BYTE_ONE);
            next_state.acc = res;
            next_state.skip = is_zero(res);
          end
          exec_subset_pkg::OP_SET_BYTE:
          begin
            mem_we = 1'b1;
            mem_wd = `BYTE_ONES;
          end
          exec_subset_pkg::OP_SET_BIT:
          begin
            mem_we = 1'b1;
            mem_wd = m | mask;
          end
          exec_subset_pkg::OP_SKIP_IF_BIT_SET:
          begin
            next_state.skip = |(m & mask);
          end
          exec_subset_pkg::OP_SKIP_IF_BIT_CLEAR:
          begin
            next_state.skip = !(|(m & mask));
          end
          exec_subset_pkg::OP_SKIP_IF_ZERO_TEST:
          begin
            next_state.skip = is_zero(m);
          end
          exec_subset_pkg::OP_COPY_AND_SKIP_IF_ZERO:
          begin
            next_state.acc = m;
            next_state.skip = is_zero(m);
          end
          exec_subset_pkg::OP_NIBBLE_EXCHANGE:
          begin
            mem_we = 1'b1;
            mem_wd = {m[3:0], m[7:4]};
          end
          exec_subset_pkg::OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR:
          begin
            next_state.acc = {m[3:0], m[7:4]};
          end
          exec_subset_pkg::OP_TABLE_READ_CURRENT_PAGE:
          begin
            next_state.prog_addr = {state.table_pointer_high, state.table_pointer_low};
            next_state.prog_rd = 1'b1;
            next_state.cycles = `TWO_CYCLES;
            next_state.fsm = exec_subset_pkg::ST_TAB_ADDR;
          end
          exec_subset_pkg::OP_TABLE_READ_LAST_PAGE:
          begin
            next_state.prog_addr = {`LAST_PAGE, state.table_pointer_low};
            next_state.prog_rd = 1'b1;
            next_state.cycles = `TWO_CYCLES;
            next_state.fsm = exec_subset_pkg::ST_TAB_ADDR;
          end
          exec_subset_pkg::OP_EXCLUSIVE_OR,
          exec_subset_pkg::OP_EXCLUSIVE_OR_IMMEDIATE:
          begin
            res = state.acc ^ ((state.op == exec_subset_pkg::OP_EXCLUSIVE_OR) ? m : state.imm);
            next_state.acc = res;
            next_state.flags.zero = is_zero(res);
          end
          exec_subset_pkg::OP_EXCLUSIVE_OR_TO_MEMORY:
          begin
            res = state.acc ^ m;
            mem_we = 1'b1;
            mem_wd = res;
            next_state.flags.zero = is_zero(res);
          end
          default:
          begin
            next_state.bad_op = 1'b1;
          end
        endcase
        if (next_state.skip)
        begin
          next_state.cycles = `TWO_CYCLES;
          next_state.fsm = exec_subset_pkg::ST_DUMMY;
        end
      end
      exec_subset_pkg::ST_DUMMY:
      begin
        next_state.fsm = exec_subset_pkg::ST_IDLE;
      end
      exec_subset_pkg::ST_TAB_ADDR:
      begin
        next_state.fsm = exec_subset_pkg::ST_TAB_DATA;
      end
      exec_subset_pkg::ST_TAB_DATA:
      begin
        mem_we = 1'b1;
        mem_wd = i_prog_data[7:0];
        next_state.table_high_byte_latch = i_prog_data[15:8];
        next_state.fsm = exec_subset_pkg::ST_IDLE;
      end
      default:
      begin
        next_state.fsm = exec_subset_pkg::ST_IDLE;
      end
    endcase
    next_state.busy = (next_state.fsm != exec_subset_pkg::ST_IDLE);
    next_state.dummy = (next_state.fsm == exec_subset_pkg::ST_DUMMY);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Data memory
  always_ff @(posedge i_clk)
  begin
    if (mem_we)
    begin
      data_mem[mem_wa] <= mem_wd;
    end
  end
  assign o_apb = state.apb;
  assign o_prog_addr = state.prog_addr;
  assign o_prog_rd = state.prog_rd;
  assign o_busy = state.busy;
  assign o_skip = state.skip;
  assign o_dummy_cycle = state.dummy;

endmodule : exec_subset

// >>> exec_subset_consts.svh
`ifndef EXEC_SUBSET_CONSTS_SVH
`define EXEC_SUBSET_CONSTS_SVH

// Register byte addresses
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_ACC 12'h008
`define REG_TABLE_PTR_LOW 12'h00C
`define REG_TABLE_PTR_HIGH 12'h010
`define REG_TABLE_HIGH_LATCH 12'h014
`define REG_CYCLES 12'h018
`define REG_MEM_BASE 12'h400

// Control register fields
`define CTRL_OP_LSB 0
`define CTRL_OP_MSB 5
`define CTRL_ADDR_LSB 8
`define CTRL_ADDR_MSB 15
`define CTRL_BIT_LSB 16
`define CTRL_BIT_MSB 18
`define CTRL_IMM_LSB 24
`define CTRL_IMM_MSB 31

// Status register fields
`define ST_C 0
`define ST_NIBBLE_BORROW 1
`define ST_Z 2
`define ST_SIGNED_WRAP 3
`define ST_BUSY 4
`define ST_SKIP 5
`define ST_BAD_OP 6

// Constant values
`define BYTE_ONES 8'hFF
`define BYTE_ZERO 8'h00
`define BYTE_ONE 8'h01
`define LAST_PAGE 8'hFF
`define ONE_CYCLE 2'h1
`define TWO_CYCLES 2'h2

`endif

// >>> exec_subset_pkg.sv
package exec_subset_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_EXEC = 3'b001,
    ST_DUMMY = 3'b010,
    ST_TAB_ADDR = 3'b011,
    ST_TAB_DATA = 3'b100
  } fsm_t;

  typedef enum logic [5:0] {
    OP_ROTATE_RIGHT_THROUGH_CARRY = 6'b000000,
    OP_ROTATE_RIGHT_CARRY_TO_ACCUMULATOR = 6'b000001,
    OP_SUBTRACT_WITH_BORROW = 6'b000010,
    OP_SUBTRACT_BORROW_TO_MEMORY = 6'b000011,
    OP_SUBTRACT = 6'b000100,
    OP_SUBTRACT_TO_MEMORY = 6'b000101,
    OP_SUBTRACT_IMMEDIATE = 6'b000110,
    OP_DECREMENT_SKIP_IF_ZERO = 6'b000111,
    OP_DECREMENT_SKIP_TO_ACCUMULATOR = 6'b001000,
    OP_INCREMENT_SKIP_IF_ZERO = 6'b001001,
    OP_INCREMENT_SKIP_TO_ACCUMULATOR = 6'b001010,
    OP_SET_BYTE = 6'b001011,
    OP_SET_BIT = 6'b001100,
    OP_SKIP_IF_BIT_SET = 6'b001101,
    OP_SKIP_IF_BIT_CLEAR = 6'b001110,
    OP_SKIP_IF_ZERO_TEST = 6'b001111,
    OP_COPY_AND_SKIP_IF_ZERO = 6'b010000,
    OP_NIBBLE_EXCHANGE = 6'b010001,
    OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR = 6'b010010,
    OP_TABLE_READ_CURRENT_PAGE = 6'b010011,
    OP_TABLE_READ_LAST_PAGE = 6'b010100,
    OP_EXCLUSIVE_OR = 6'b010101,
    OP_EXCLUSIVE_OR_TO_MEMORY = 6'b010110,
    OP_EXCLUSIVE_OR_IMMEDIATE = 6'b010111
  } op_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic carry;
    logic nibble_borrow_flag;
    logic zero;
    logic signed_wrap_flag;
  } flags_t;

  typedef struct packed {
    fsm_t fsm;
    op_t op;
    logic [7:0] addr;
    logic [2:0] bitsel;
    logic [7:0] imm;
    logic [7:0] acc;
    flags_t flags;
    logic [7:0] table_pointer_low;
    logic [7:0] table_pointer_high;
    logic [7:0] table_high_byte_latch;
    logic skip;
    logic bad_op;
    logic [1:0] cycles;
    logic [15:0] prog_addr;
    logic prog_rd;
    logic busy;
    logic dummy;
    apb_rsp_t apb;
  } state_t;

endpackage : exec_subset_pkg

// >>> exec_subset_asserts.sv
`timescale 1ns/1ps
module exec_subset_asserts (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Register bus
  input wire exec_subset_pkg::apb_req_t i_apb,
  input wire exec_subset_pkg::apb_rsp_t o_apb,
  // Program memory and status
  input wire logic [15:0] o_prog_addr,
  input wire logic o_prog_rd,
  input wire logic [15:0] i_prog_data,
  input wire logic o_busy,
  input wire logic o_skip,
  input wire logic o_dummy_cycle
);
  logic ctrl_wr;
  logic [5:0] last_op;

  // Accepted instruction start
  assign ctrl_wr = i_apb.psel && i_apb.penable && i_apb.pwrite && o_apb.pready
    && !o_apb.pslverr && i_apb.paddr == 12'h000;

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      last_op <= 6'h00;
    end
    else if (ctrl_wr)
    begin
      last_op <= i_apb.pwdata[5:0];
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  sequence s_dummy_tail;
    o_dummy_cycle ##1 !o_dummy_cycle && !o_busy;
  endsequence

  sequence s_table_fetch;
    ##[0:1] o_prog_rd ##1 !o_prog_rd;
  endsequence

  a_skip_has_dummy: assert property (o_dummy_cycle |-> o_skip)
    else $error("dummy cycle without a skip");
  a_dummy_once: assert property ($rose(o_dummy_cycle) |-> s_dummy_tail)
    else $error("dummy cycle not single");
  a_skip_two_cycles: assert property ($fell(o_busy) && o_skip |-> $past(o_dummy_cycle))
    else $error("skip finished without dummy cycle");
  a_start_busy: assert property (ctrl_wr && i_apb.pwdata[5:0] <= 6'h17 |=> o_busy)
    else $error("instruction did not start");
  a_busy_bounded: assert property ($rose(o_busy) |-> ##[1:3] !o_busy)
    else $error("instruction too long");
  a_table_fetch: assert property ($rose(o_busy) && (last_op == 6'h13 || last_op == 6'h14)
    |-> s_table_fetch)
    else $error("table read without single fetch");
  a_fetch_in_busy: assert property (o_prog_rd |-> o_busy)
    else $error("fetch outside instruction");
  a_last_page: assert property (o_prog_rd && last_op == 6'h14 |-> o_prog_addr[15:8] == 8'hFF)
    else $error("last page fetch address wrong");
  a_plain_no_skip: assert property ($fell(o_busy) && last_op <= 6'h06 |-> !o_skip)
    else $error("arithmetic instruction skipped");
endmodule : exec_subset_asserts

bind exec_subset exec_subset_asserts i_exec_subset_asserts (
  .i_clk(i_clk),
  .i_srst(i_srst),
  .i_apb(i_apb),
  .o_apb(o_apb),
  .o_prog_addr(o_prog_addr),
  .o_prog_rd(o_prog_rd),
  .i_prog_data(i_prog_data),
  .o_busy(o_busy),
  .o_skip(o_skip),
  .o_dummy_cycle(o_dummy_cycle)
);

// >>> test_exec_subset.sv
`timescale 1ns/1ps
module test_exec_subset;
  logic clk;
  logic srst;
  exec_subset_pkg::apb_req_t apb;
  exec_subset_pkg::apb_rsp_t rsp;
  logic [15:0] prog_addr;
  logic prog_rd;
  logic [15:0] prog_data;
  logic busy;
  logic skip;
  logic dummy;
  logic [31:0] d;
  logic e;
  logic [7:0] idx;
  int error_cnt;
  int compares;
  int cyc;
  int dum;

  exec_subset i_exec_subset (
    .i_clk(clk),
    .i_srst(srst),
    .i_apb(apb),
    .o_apb(rsp),
    .o_prog_addr(prog_addr),
    .o_prog_rd(prog_rd),
    .i_prog_data(prog_data),
    .o_busy(busy),
    .o_skip(skip),
    .o_dummy_cycle(dummy)
  );

  always
  begin
    #4 clk = ~clk;
  end

  // Program word is its address with bytes exchanged
  always @(posedge clk)
  begin
    prog_data <= prog_rd ? {prog_addr[7:0], prog_addr[15:8]} : ~prog_data;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  task wrap_up;
    if (error_cnt == 0 && compares > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] rdata, output logic err);
    @(posedge clk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge clk);
    apb.penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (rsp.pready !== 1'b1);
    rdata = rsp.prdata;
    err = rsp.pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask : xfer

  task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    xfer(1'b0, a, 32'h0, d, e);
    chk(d & m, x);
  endtask : rd

  // Preload flags, accumulator and byte, run one instruction, check results
  task step(input logic [5:0] op, input logic [2:0] b, input logic [7:0] im,
    input logic [7:0] a0, input logic [7:0] m0, input logic [3:0] f0,
    input logic [7:0] a1, input logic [7:0] m1, input logic [3:0] f1, input logic sk);
    xfer(1'b1, 12'h004, {28'h0, f0}, d, e);
    xfer(1'b1, 12'h008, {24'h0, a0}, d, e);
    xfer(1'b1, {2'h1, idx, 2'h0}, {24'h0, m0}, d, e);
    xfer(1'b1, 12'h000, {im, 5'h0, b, idx, 2'h0, op}, d, e);
    dum = 0;
    do
    begin
      @(posedge clk);
      dum = dum + int'(dummy);
    end
    while (busy !== 1'b0);
    chk({31'h0, skip}, {31'h0, sk});
    chk(dum, {31'h0, sk});
    rd(12'h008, 32'hFF, {24'h0, a1});
    rd({2'h1, idx, 2'h0}, 32'hFF, {24'h0, m1});
    rd(12'h004, 32'hF, {28'h0, f1});
    rd(12'h018, 32'h3, (sk || op == 6'h13 || op == 6'h14) ? 32'h2 : 32'h1);
    if (op == 6'h13 || op == 6'h14)
    begin
      rd(12'h014, 32'hFF, 32'h5A);
    end
    idx = idx + 8'h01;
  endtask : step

  initial
  begin
    clk = 1'b0;
    srst = 1'b1;
    apb = '0;
    prog_data = 16'h0;
    idx = 8'hE4;
    error_cnt = 0;
    compares = 0;
    cyc = 0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd(12'h004, 32'h7F, 32'h0);
    xfer(1'b0, 12'h020, 32'h0, d, e);
    chk({31'h0, e}, 32'h1);
    xfer(1'b0, 12'h401, 32'h0, d, e);
    chk({31'h0, e}, 32'h1);
    xfer(1'b1, 12'h014, 32'h0, d, e);
    chk({31'h0, e}, 32'h1);
    xfer(1'b1, 12'h00C, 32'h5A, d, e);
    xfer(1'b1, 12'h010, 32'h12, d, e);
    step(6'h00, 3'h0, 8'h00, 8'h00, 8'hA4, 4'hF, 8'h00, 8'hD2, 4'hE, 1'b0);
    step(6'h01, 3'h0, 8'h00, 8'h00, 8'h03, 4'h0, 8'h01, 8'h03, 4'h1, 1'b0);
    step(6'h02, 3'h0, 8'h00, 8'h50, 8'h70, 4'h0, 8'hDF, 8'h70, 4'h2, 1'b0);
    step(6'h03, 3'h0, 8'h00, 8'h80, 8'h01, 4'h1, 8'h80, 8'h7F, 4'hB, 1'b0);
    step(6'h04, 3'h0, 8'h00, 8'h10, 8'h01, 4'h0, 8'h0F, 8'h01, 4'h3, 1'b0);
    step(6'h05, 3'h0, 8'h00, 8'h33, 8'h33, 4'h0, 8'h33, 8'h00, 4'h5, 1'b0);
    step(6'h06, 3'h0, 8'hFF, 8'h7F, 8'h00, 4'h0, 8'h80, 8'h00, 4'h8, 1'b0);
    step(6'h07, 3'h0, 8'h00, 8'h00, 8'h01, 4'hF, 8'h00, 8'h00, 4'hF, 1'b1);
    step(6'h08, 3'h0, 8'h00, 8'h77, 8'h05, 4'hF, 8'h04, 8'h05, 4'hF, 1'b0);
    step(6'h09, 3'h0, 8'h00, 8'h00, 8'hFF, 4'h0, 8'h00, 8'h00, 4'h0, 1'b1);
    step(6'h0A, 3'h0, 8'h00, 8'h77, 8'hFF, 4'h6, 8'h00, 8'hFF, 4'h6, 1'b1);
    step(6'h0B, 3'h0, 8'h00, 8'h00, 8'h00, 4'hA, 8'h00, 8'hFF, 4'hA, 1'b0);
    step(6'h0C, 3'h7, 8'h00, 8'h00, 8'h01, 4'h5, 8'h00, 8'h81, 4'h5, 1'b0);
    step(6'h0D, 3'h0, 8'h00, 8'h00, 8'h01, 4'hF, 8'h00, 8'h01, 4'hF, 1'b1);
    step(6'h0D, 3'h3, 8'h00, 8'h00, 8'hF7, 4'h0, 8'h00, 8'hF7, 4'h0, 1'b0);
    step(6'h0E, 3'h6, 8'h00, 8'h00, 8'hBF, 4'h9, 8'h00, 8'hBF, 4'h9, 1'b1);
    step(6'h0E, 3'h6, 8'h00, 8'h00, 8'h40, 4'h0, 8'h00, 8'h40, 4'h0, 1'b0);
    step(6'h0F, 3'h0, 8'h00, 8'h5A, 8'h00, 4'hF, 8'h5A, 8'h00, 4'hF, 1'b1);
    step(6'h0F, 3'h0, 8'h00, 8'h00, 8'h80, 4'h0, 8'h00, 8'h80, 4'h0, 1'b0);
    step(6'h10, 3'h0, 8'h00, 8'h33, 8'h00, 4'h3, 8'h00, 8'h00, 4'h3, 1'b1);
    step(6'h10, 3'h0, 8'h00, 8'h00, 8'h9C, 4'h0, 8'h9C, 8'h9C, 4'h0, 1'b0);
    step(6'h11, 3'h0, 8'h00, 8'h00, 8'h3C, 4'hF, 8'h00, 8'hC3, 4'hF, 1'b0);
    step(6'h12, 3'h0, 8'h00, 8'h00, 8'h12, 4'h0, 8'h21, 8'h12, 4'h0, 1'b0);
    step(6'h13, 3'h0, 8'h00, 8'h44, 8'h00, 4'h6, 8'h44, 8'h12, 4'h6, 1'b0);
    step(6'h14, 3'h0, 8'h00, 8'h44, 8'h00, 4'h0, 8'h44, 8'hFF, 4'h0, 1'b0);
    step(6'h15, 3'h0, 8'h00, 8'hF0, 8'hF0, 4'h1, 8'h00, 8'hF0, 4'h5, 1'b0);
    step(6'h16, 3'h0, 8'h00, 8'h0F, 8'hF0, 4'h4, 8'h0F, 8'hFF, 4'h0, 1'b0);
    step(6'h17, 3'h0, 8'hAA, 8'h55, 8'h00, 4'h4, 8'hFF, 8'h00, 4'h0, 1'b0);
    xfer(1'b1, 12'h000, 32'h3F, d, e);
    rd(12'h004, 32'h40, 32'h40);
    wrap_up();
  end
endmodule : test_exec_subset
